/* hw/csr_pkg.sv */
// Package for the CAN status, FIFO control and interrupt register group.
// Assumes a 16-bit register port; constants are shared by the two design files.
package csr_pkg;
	// ====================================================================
	// Register offsets (word index on the plain register port)
	localparam logic [3:0] OFS_CONTROL_TWO  = 4'h0;
	localparam logic [3:0] OFS_INT_CODE     = 4'h1;
	localparam logic [3:0] OFS_FIFO_CONTROL = 4'h2;
	localparam logic [3:0] OFS_FIFO_STATUS  = 4'h3;
	localparam logic [3:0] OFS_INT_FLAGS    = 4'h4;
	localparam logic [3:0] OFS_INT_ENABLES  = 4'h5;
	localparam logic [3:0] OFS_ERROR_COUNTS = 4'h6;
	// ====================================================================
	// Interrupt flag positions (low byte; bit 4 unimplemented)
	localparam int FLG_TX_BUF   = 0;
	localparam int FLG_RX_BUF   = 1;
	localparam int FLG_RX_OVF   = 2;
	localparam int FLG_FIFO_AF  = 3;
	localparam int FLG_ERROR    = 5;
	localparam int FLG_WAKEUP   = 6;
	localparam int FLG_INVALID  = 7;
	localparam logic [7:0] FLAG_MASK  = 8'hEF;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	// ====================================================================
	// Field widths, limits and reset values
	localparam logic [4:0] DBF_MAX_VALID   = 5'h11;
	localparam logic [4:0] FILTER_MAX      = 5'h0F;
	localparam logic [2:0] BUFSZ_RESERVED  = 3'h7;
	localparam logic [5:0] PTR_MAX         = 6'h1F;
	localparam logic [2:0] FCTRL_SZ_RESET  = 3'h0;
	localparam logic [4:0] FCTRL_FSA_RESET = 5'h00;
	// ====================================================================
	// Interrupt cause codes
	localparam logic [6:0] IC_NONE     = 7'h40;
	localparam logic [6:0] IC_ERROR    = 7'h41;
	localparam logic [6:0] IC_WAKEUP   = 7'h42;
	localparam logic [6:0] IC_RX_OVF   = 7'h43;
	localparam logic [6:0] IC_FIFO_AF  = 7'h44;
	localparam logic [6:0] IC_BUF_LAST = 7'h0F;
	localparam logic [6:0] IC_TRB_LAST = 7'h07;
endpackage

/* hw/csr_code_enc.sv */
// Priority encoder that turns pending enabled causes into a cause code.
// Assumes buffer-event identifiers arrive already latched by the caller.
`timescale 1ns/1ps
module csr_code_enc
	import csr_pkg::*;
(
	input  wire logic [7:0] act_i,
	input  wire logic [3:0] tx_buf_i,
	input  wire logic [3:0] rx_buf_i,
	output logic      [6:0] code_o
);
	// ====================================================================
	// Priority: error, tx buffer, rx buffer, wake-up, overflow, almost full
	always_comb begin
		code_o = IC_NONE;
		if (act_i[FLG_ERROR])
			code_o = IC_ERROR;
		else if (act_i[FLG_TX_BUF])
			code_o = {4'h0, tx_buf_i[2:0]};                            // Only TRB0..7
		else if (act_i[FLG_RX_BUF])
			code_o = {3'h0, rx_buf_i};
		else if (act_i[FLG_WAKEUP])
			code_o = IC_WAKEUP;
		else if (act_i[FLG_RX_OVF])
			code_o = IC_RX_OVF;
		else if (act_i[FLG_FIFO_AF])
			code_o = IC_FIFO_AF;
	end
endmodule

/* hw/csr_regs.sv */
// CAN status, interrupt, FIFO control and error count register group.
// Assumes protocol engine events are one-cycle pulses synchronous to clk_i.
`timescale 1ns/1ps
module csr_regs
	import csr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire logic [4:0]  data_bit_filter_count_i,
	input  wire logic        msg_stored_i,
	input  wire logic [3:0]  matched_filter_number_i,
	input  wire logic        tx_done_i,
	input  wire logic [3:0]  tx_buf_i,
	input  wire logic        rx_done_i,
	input  wire logic [3:0]  rx_buf_i,
	input  wire logic        invalid_msg_i,
	input  wire logic        wakeup_i,
	input  wire logic        rx_overflow_i,
	input  wire logic        fifo_almost_full_i,
	input  wire logic        fifo_write_adv_i,
	input  wire logic        fifo_read_adv_i,
	input  wire logic [7:0]  tx_error_counter_i,
	input  wire logic [7:0]  rx_error_counter_i,
	input  wire logic        tx_bus_off_i,
	input  wire logic        tx_error_passive_i,
	input  wire logic        rx_error_passive_i,
	input  wire logic        tx_error_warning_i,
	input  wire logic        rx_error_warning_i,
	output logic [2:0]       ram_buffer_count_sel_o,
	output logic [4:0]       fifo_first_buffer_o,
	output logic             irq_o
);
	// ====================================================================
	// Storage
	logic [4:0] dbf_r;
	logic [4:0] filt_r;
	logic [3:0] txb_r;
	logic [3:0] rxb_r;
	logic [2:0] bufsz_r;
	logic [4:0] fsa_r;
	logic [5:0] wptr_r;
	logic [5:0] rptr_r;
	logic [5:0] estat_r;
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [7:0] enab_r;
	logic [7:0] tec_r;
	logic [7:0] rec_r;
	logic [6:0] code;
	logic [7:0] events;
	logic [5:0] estat_nxt;
	logic       err_event;

	// ====================================================================
	// Read-only filter count; out-of-range selections read as zero (disabled)
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			dbf_r <= 5'h00;
		else if (data_bit_filter_count_i <= DBF_MAX_VALID)
			dbf_r <= data_bit_filter_count_i;
		else
			dbf_r <= 5'h00;
	end

	// Filter hit follows the most recently stored message; every filter number is kept
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			filt_r <= 5'h00;
		else if (msg_stored_i)
			filt_r <= {1'b0, matched_filter_number_i};
	end

	// Latch buffer numbers of the latest tx and rx completion
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			txb_r <= 4'h0;
			rxb_r <= 4'h0;
		end else begin
			if (tx_done_i)
				txb_r <= {1'b0, tx_buf_i[2:0]};                          // Only TRB0..7 transmit
			if (rx_done_i)
				rxb_r <= rx_buf_i;
		end
	end

	// ====================================================================
	// FIFO control: reserved size code is refused so the area stays legal
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			bufsz_r <= FCTRL_SZ_RESET;
			fsa_r   <= FCTRL_FSA_RESET;
		end else if (wr_i && addr_i == OFS_FIFO_CONTROL) begin
			if (wdata_i[15:13] != BUFSZ_RESERVED)
				bufsz_r <= wdata_i[15:13];
			fsa_r <= wdata_i[4:0];
		end
	end

	// FIFO pointers wrap back to the first FIFO buffer after buffer 31
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wptr_r <= 6'h00;
			rptr_r <= 6'h00;
		end else if (wr_i && addr_i == OFS_FIFO_CONTROL) begin
			wptr_r <= {1'b0, wdata_i[4:0]};                            // Restart at new area
			rptr_r <= {1'b0, wdata_i[4:0]};
		end else begin
			if (fifo_write_adv_i)
				wptr_r <= (wptr_r >= PTR_MAX) ? {1'b0, fsa_r} : wptr_r + 6'h01;
			if (fifo_read_adv_i)
				rptr_r <= (rptr_r >= PTR_MAX) ? {1'b0, fsa_r} : rptr_r + 6'h01;
		end
	end

	// ====================================================================
	// Error states and counters mirror the protocol engine
	assign estat_nxt = {tx_bus_off_i,
	                    tx_error_passive_i, rx_error_passive_i,
	                    tx_error_warning_i, rx_error_warning_i,
	                    tx_error_warning_i | rx_error_warning_i};

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			estat_r <= 6'h00;
			tec_r   <= 8'h00;
			rec_r   <= 8'h00;
		end else begin
			estat_r <= estat_nxt;
			tec_r   <= tx_error_counter_i;
			rec_r   <= rx_error_counter_i;
		end
	end

	// A new error state entered raises the error flag
	assign err_event = |(estat_nxt & ~estat_r);

	// ====================================================================
	// Sticky flags: set wins over a write of zero in the same cycle
	always_comb begin
		events = 8'h00;
		events[FLG_TX_BUF]  = tx_done_i;
		events[FLG_RX_BUF]  = rx_done_i;
		events[FLG_RX_OVF]  = rx_overflow_i;
		events[FLG_FIFO_AF] = fifo_almost_full_i;
		events[FLG_ERROR]   = err_event;
		events[FLG_WAKEUP]  = wakeup_i;
		events[FLG_INVALID] = invalid_msg_i;
		flags_nxt = flags_r;
		if (wr_i && addr_i == OFS_INT_FLAGS)
			flags_nxt = flags_r & wdata_i[7:0];
		flags_nxt = (flags_nxt | events) & FLAG_MASK;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			flags_r <= FLAG_RESET;
		else
			flags_r <= flags_nxt;
	end

	// Enables share the flag layout
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			enab_r <= 8'h00;
		else if (wr_i && addr_i == OFS_INT_ENABLES)
			enab_r <= wdata_i[7:0] & FLAG_MASK;
	end

	// Level interrupt; code reports only enabled pending causes
	assign irq_o = |(flags_r & enab_r);

	csr_code_enc u_enc (
		.act_i    (flags_r & enab_r),
		.tx_buf_i (txb_r),
		.rx_buf_i (rxb_r),
		.code_o   (code)
	);

	assign ram_buffer_count_sel_o = bufsz_r;
	assign fifo_first_buffer_o    = fsa_r;

	// ====================================================================
	// Read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			rdata_o <= 16'h0000;
		else if (rd_i) begin
			case (addr_i)
				OFS_CONTROL_TWO:  rdata_o <= {11'h000, dbf_r};
				OFS_INT_CODE:     rdata_o <= {3'h0, filt_r, 1'b0, code};
				OFS_FIFO_CONTROL: rdata_o <= {bufsz_r, 8'h00, fsa_r};
				OFS_FIFO_STATUS:  rdata_o <= {2'h0, wptr_r, 2'h0, rptr_r};
				OFS_INT_FLAGS:    rdata_o <= {2'h0, estat_r, flags_r};
				OFS_INT_ENABLES:  rdata_o <= {8'h00, enab_r};
				OFS_ERROR_COUNTS: rdata_o <= {tec_r, rec_r};
				default:          rdata_o <= 16'h0000;
			endcase
		end else
			rdata_o <= 16'h0000;
	end

	// ====================================================================
	// Checks
	property p_code_legal;
		@(posedge clk_i) disable iff (reset_i)
		(code <= IC_BUF_LAST) || (code >= IC_NONE && code <= IC_FIFO_AF);
	endproperty
	a_code_legal: assert property (p_code_legal) else $error("reserved code");

	property p_code_none;
		@(posedge clk_i) disable iff (reset_i)
		((flags_r & enab_r) == 8'h00) |-> code == IC_NONE;
	endproperty
	a_code_none: assert property (p_code_none) else $error("code not none");

	property p_err_pri;
		@(posedge clk_i) disable iff (reset_i)
		(flags_r[FLG_ERROR] && enab_r[FLG_ERROR]) |-> code == IC_ERROR;
	endproperty
	a_err_pri: assert property (p_err_pri) else $error("error not top");

	property p_set_wins;
		@(posedge clk_i) disable iff (reset_i)
		tx_done_i |=> flags_r[FLG_TX_BUF];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag lost");

	property p_one_keeps;
		@(posedge clk_i) disable iff (reset_i)
		(wr_i && addr_i == OFS_INT_FLAGS && wdata_i[7:0] == 8'hFF) |=>
			(flags_r & $past(flags_r)) == $past(flags_r);
	endproperty
	a_one_keeps: assert property (p_one_keeps) else $error("one cleared flag");

	property p_irq;
		@(posedge clk_i) disable iff (reset_i)
		irq_o == |(flags_r & enab_r);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	property p_warn;
		@(posedge clk_i) disable iff (reset_i)
		(tx_error_warning_i || rx_error_warning_i) |=> estat_r[0];
	endproperty
	a_warn: assert property (p_warn) else $error("combined warning");

	property p_err_flag;
		@(posedge clk_i) disable iff (reset_i)
		$rose(tx_bus_off_i) |=> ##1 flags_r[FLG_ERROR];
	endproperty
	a_err_flag: assert property (p_err_flag) else $error("no error flag");

	property p_ptr;
		@(posedge clk_i) disable iff (reset_i)
		wptr_r <= PTR_MAX && rptr_r <= PTR_MAX;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer range");

	property p_rd_zero;
		@(posedge clk_i) disable iff (reset_i)
		(rd_i && addr_i > OFS_ERROR_COUNTS) |=> rdata_o == 16'h0000;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("unmapped nonzero");

	// Field ranges, status mirrors and flag clearing; the first cycle after
	// reset is skipped where a mirror would compare against a reset value
	property p_dbf_range;
		@(posedge clk_i) disable iff (reset_i)
		dbf_r <= DBF_MAX_VALID;
	endproperty
	a_dbf_range: assert property (p_dbf_range) else $error("filter count range");

	property p_filt_range;
		@(posedge clk_i) disable iff (reset_i)
		filt_r <= FILTER_MAX;
	endproperty
	a_filt_range: assert property (p_filt_range) else $error("filter hit range");

	property p_tx_code;
		@(posedge clk_i) disable iff (reset_i)
		(flags_r[FLG_TX_BUF] && enab_r[FLG_TX_BUF] && !(flags_r[FLG_ERROR] && enab_r[FLG_ERROR]))
			|-> code <= IC_TRB_LAST;
	endproperty
	a_tx_code: assert property (p_tx_code) else $error("tx buffer code");

	property p_size_legal;
		@(posedge clk_i) disable iff (reset_i)
		bufsz_r != BUFSZ_RESERVED;
	endproperty
	a_size_legal: assert property (p_size_legal) else $error("reserved size");

	property p_wrap;
		@(posedge clk_i) disable iff (reset_i)
		(fifo_write_adv_i && !(wr_i && addr_i == OFS_FIFO_CONTROL) && wptr_r == PTR_MAX)
			|=> wptr_r == {1'b0, $past(fsa_r)};
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer wrap");

	property p_bus_off;
		@(posedge clk_i) disable iff (reset_i)
		!$past(reset_i) |-> estat_r[5] == $past(tx_bus_off_i);
	endproperty
	a_bus_off: assert property (p_bus_off) else $error("bus off bit");

	property p_passive;
		@(posedge clk_i) disable iff (reset_i)
		!$past(reset_i) |-> estat_r[4:3] == {$past(tx_error_passive_i), $past(rx_error_passive_i)};
	endproperty
	a_passive: assert property (p_passive) else $error("passive bits");

	property p_counts;
		@(posedge clk_i) disable iff (reset_i)
		!$past(reset_i) |-> tec_r == $past(tx_error_counter_i) && rec_r == $past(rx_error_counter_i);
	endproperty
	a_counts: assert property (p_counts) else $error("error counts");

	property p_unimpl;
		@(posedge clk_i) disable iff (reset_i)
		(flags_r & ~FLAG_MASK) == 8'h00 && (enab_r & ~FLAG_MASK) == 8'h00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

	property p_clear_zero;
		@(posedge clk_i) disable iff (reset_i)
		(wr_i && addr_i == OFS_INT_FLAGS && !wdata_i[FLG_INVALID] && !invalid_msg_i)
			|=> !flags_r[FLG_INVALID];
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("zero did not clear");

	c_irq:  cover property (@(posedge clk_i) disable iff (reset_i) $rose(irq_o));
	c_buf:  cover property (@(posedge clk_i) disable iff (reset_i) code == 7'h0C);
	c_wrap: cover property (@(posedge clk_i) disable iff (reset_i)
		fifo_write_adv_i && wptr_r == PTR_MAX);
	c_err:  cover property (@(posedge clk_i) disable iff (reset_i) code == IC_ERROR);
endmodule

/* test/csr_engine_model.sv */
// Behavioural model of the protocol engine that feeds the register group.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/1ps
module csr_engine_model (
	input  wire logic       clk_i,
	output logic      [8:0] ev_o,
	output logic      [3:0] tx_buf_o,
	output logic      [3:0] rx_buf_o,
	output logic      [3:0] filt_o,
	output logic      [4:0] dbf_o,
	output logic      [7:0] tec_o,
	output logic      [7:0] rec_o,
	output logic      [4:0] est_o
);
	// ====================================================================
	// Idle levels at time zero
	initial begin
		ev_o = 9'h000;
		tx_buf_o = 4'h0;
		rx_buf_o = 4'h0;
		filt_o = 4'h0;
		dbf_o = 5'h00;
		tec_o = 8'h00;
		rec_o = 8'h00;
		est_o = 5'h00;
	end
	// One-cycle event pulse; identifiers only count beside the pulse,
	// so they flip afterwards to expose a late capture
	task automatic fire(input logic [8:0] m, input logic [3:0] tid, rid, fl);
		@(posedge clk_i);
		ev_o <= m;
		tx_buf_o <= tid;
		rx_buf_o <= rid;
		filt_o <= fl;
		@(posedge clk_i);
		ev_o <= 9'h000;
		tx_buf_o <= ~tid;
		rx_buf_o <= ~rid;
		filt_o <= ~fl;
	endtask
	// Level status; a few cycles let the registered copy and edge detect settle
	task automatic levels(input logic [4:0] d, input logic [7:0] t, r, input logic [4:0] s);
		@(posedge clk_i);
		dbf_o <= d;
		tec_o <= t;
		rec_o <= r;
		est_o <= s;
		repeat (3) @(posedge clk_i);
	endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the CAN status and interrupt register group.
// Assumes the engine model drives all event and status inputs.
`timescale 1ns/1ps
module tb_top
	import csr_pkg::*;
;
	// ====================================================================
	// Signals and tables
	logic        clk_i, reset_i, wr_i, rd_i, irq_o;
	logic [3:0]  addr_i, txb, rxb, filt;
	logic [15:0] wdata_i, rdata_o;
	logic [2:0]  sel;
	logic [4:0]  first, dbf, est;
	logic [7:0]  tec, rec;
	logic [8:0]  ev;
	int          mismatches, comparisons, cycles;
	localparam logic [3:0]  RO_OFS [4] = '{OFS_CONTROL_TWO, OFS_INT_CODE, OFS_FIFO_STATUS,
		OFS_ERROR_COUNTS};
	localparam logic [15:0] RO_EXP [4] = '{16'h0000, 16'h0040, 16'h0000, 16'hA53C};
	localparam logic [8:0]  PM [3] = '{9'h040, 9'h040, 9'h080};
	localparam logic [15:0] PE [3] = '{16'h1F1E, 16'h1E1E, 16'h1E1F};
	localparam logic [7:0]  EHI [5] = '{8'h20, 8'h10, 8'h08, 8'h05, 8'h03};
	localparam int          ORD [7] = '{5, 0, 1, 6, 2, 3, 7};
	localparam logic [6:0]  CODES [7] = '{7'h41, 7'h07, 7'h0C, 7'h42, 7'h43, 7'h44, 7'h40};
	// ====================================================================
	// Design and engine model
	csr_regs uut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .data_bit_filter_count_i(dbf),
		.msg_stored_i(ev[8]), .matched_filter_number_i(filt), .tx_done_i(ev[0]),
		.tx_buf_i(txb), .rx_done_i(ev[1]), .rx_buf_i(rxb), .invalid_msg_i(ev[4]),
		.wakeup_i(ev[5]), .rx_overflow_i(ev[2]), .fifo_almost_full_i(ev[3]),
		.fifo_write_adv_i(ev[6]), .fifo_read_adv_i(ev[7]), .tx_error_counter_i(tec),
		.rx_error_counter_i(rec), .tx_bus_off_i(est[4]), .tx_error_passive_i(est[3]),
		.rx_error_passive_i(est[2]), .tx_error_warning_i(est[1]),
		.rx_error_warning_i(est[0]), .ram_buffer_count_sel_o(sel),
		.fifo_first_buffer_o(first), .irq_o(irq_o));
	csr_engine_model eng (.clk_i(clk_i), .ev_o(ev), .tx_buf_o(txb), .rx_buf_o(rxb),
		.filt_o(filt), .dbf_o(dbf), .tec_o(tec), .rec_o(rec), .est_o(est));
	// ====================================================================
	// Clock, watchdog and tasks
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Cuts a hang short well beyond the few hundred cycles the tests need
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, exp, input string what);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// One-cycle strobes; a cycle passes between calls so no signal is set twice
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp, what);
	endtask
	task automatic irq(input logic e);
		@(posedge clk_i);
		#1 chk({15'h0000, irq_o}, {15'h0000, e}, "irq level");
	endtask
	task automatic rst;
		reset_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
	endtask
	task automatic st(input logic [4:0] s);
		eng.levels(5'h12, 8'hA5, 8'h3C, s);
	endtask
	// ====================================================================
	// Main sequence
	initial begin
		logic [7:0] keep;
		reset_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		rst();
		for (int i = 0; i < 8; i++) begin
			rd(i[3:0], (i == 1) ? 16'h0040 : 16'h0000, "reset");
		end
		rd(4'hF, 16'h0000, "unmapped");
		eng.levels(5'h11, 8'hA5, 8'h3C, 5'h00);
		rd(OFS_CONTROL_TWO, 16'h0011, "filter count");
		st(5'h00);
		// Read-only places ignore writes; 0x12 is an invalid count
		for (int i = 0; i < 4; i++) begin
			wr(RO_OFS[i], 16'hFFFF);
			rd(RO_OFS[i], RO_EXP[i], "read only");
		end
		for (int s = 0; s < 7; s++) begin
			wr(OFS_FIFO_CONTROL, {s[2:0], 8'h00, s[4:0]});
			rd(OFS_FIFO_CONTROL, {s[2:0], 8'h00, s[4:0]}, "fifo ctrl");
			chk({8'h00, sel, first}, {8'h00, s[2:0], s[4:0]}, "ctrl outputs");
		end
		wr(OFS_FIFO_CONTROL, 16'hFFFE);
		rd(OFS_FIFO_CONTROL, 16'hC01E, "reserved size");
		rd(OFS_FIFO_STATUS, 16'h1E1E, "pointer start");
		for (int i = 0; i < 3; i++) begin
			eng.fire(PM[i], 4'h0, 4'h0, 4'h0);
			rd(OFS_FIFO_STATUS, PE[i], "pointers");
		end
		for (int i = 0; i < 5; i++) begin
			st(5'h10 >> i);
			rd(OFS_INT_FLAGS, {EHI[i], 8'h20}, "error state");
			st(5'h00);
			wr(OFS_INT_FLAGS, 16'h0000);
			rd(OFS_INT_FLAGS, 16'h0000, "flag clear");
		end
		// All causes pending at once, then cleared in priority order
		st(5'h08);
		st(5'h00);
		eng.fire(9'h13F, 4'h7, 4'hC, 4'h9);
		rd(OFS_INT_FLAGS, 16'h00EF, "all flags");
		irq(1'b0);
		rd(OFS_INT_CODE, 16'h0940, "masked code");
		wr(OFS_INT_FLAGS, 16'hFFFF);
		rd(OFS_INT_FLAGS, 16'h00EF, "write one keeps");
		wr(OFS_INT_ENABLES, 16'h0010);
		irq(1'b0);
		wr(OFS_INT_ENABLES, 16'hFFFF);
		rd(OFS_INT_ENABLES, 16'h00EF, "enables");
		keep = 8'hEF;
		for (int j = 0; j < 7; j++) begin
			rd(OFS_INT_CODE, {8'h09, 1'b0, CODES[j]}, "cause code");
			irq(1'b1);
			keep = keep & ~(8'h01 << ORD[j]);
			wr(OFS_INT_FLAGS, {8'h00, keep});
		end
		rd(OFS_INT_FLAGS, 16'h0000, "all cleared");
		irq(1'b0);
		eng.fire(9'h100, 4'h0, 4'h0, 4'hF);
		rd(OFS_INT_CODE, 16'h0F40, "latest filter");
		// A second reset in mid-run restores defaults
		rst();
		rd(OFS_INT_CODE, 16'h0040, "reset code");
		rd(OFS_FIFO_CONTROL, 16'h0000, "reset ctrl");
		rd(OFS_INT_ENABLES, 16'h0000, "reset enables");
		complete_run();
	end
endmodule
